// ---- rtl/tfpc_pkg.sv ----
`default_nettype none

package tfpc_pkg;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TIMEBASE_HZ     = 30;
  localparam int unsigned STARTUP_PERIODS = 64;

  // ----------------------------------------------------------------
  // control level to duty mapping (level code = fraction of supply)
  // ----------------------------------------------------------------
  localparam int unsigned LEVEL_FULL  = 256;
  localparam int unsigned CTRL_LO_PCT = 30;
  localparam int unsigned CTRL_HI_PCT = 70;
  localparam logic [7:0]  LEVEL_LO    = 8'(CTRL_LO_PCT * LEVEL_FULL / 100);
  localparam logic [7:0]  LEVEL_HI    = 8'(CTRL_HI_PCT * LEVEL_FULL / 100);
  localparam logic [7:0]  DUTY_SPAN   = 8'(LEVEL_HI - LEVEL_LO);
  localparam int unsigned TRI_STEPS   = 2 * (int'(DUTY_SPAN) - 1);
  localparam int unsigned STEP_CYCLES = CLK_HZ / (TIMEBASE_HZ * TRI_STEPS);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFS            = 8'h00;
  localparam logic [7:0]  STATUS_OFS          = 8'h04;
  localparam logic [7:0]  STARTUP_OFS         = 8'h08;
  localparam logic [7:0]  DUTY_OFS            = 8'h0C;
  localparam int unsigned CTRL_SLEEP_EN_BIT   = 0;
  localparam int unsigned CTRL_FORCE_FULL_BIT = 1;
  localparam logic [1:0]  CTRL_RST            = 2'h1;
  localparam int unsigned STATUS_STATE_LSB    = 0;
  localparam int unsigned STATUS_DRIVE_BIT    = 2;
  localparam int unsigned STATUS_DRIVE_OE_BIT = 3;
  localparam int unsigned STATUS_FAULT_BIT    = 4;
  localparam int unsigned STATUS_FPIN_BIT     = 5;
  localparam int unsigned STATUS_FLAGS_LSB    = 8;
  localparam int unsigned DUTY_SEC_LSB        = 8;
  localparam int unsigned DUTY_APPLIED_LSB    = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HALT    = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_STARTUP = 2'b11,
    ST_RUN     = 2'b10
  } tfpc_state_t;

  typedef struct packed {
    logic secondary_above_wake;
    logic primary_above_wake;
    logic secondary_below_sleep;
    logic primary_below_sleep;
    logic primary_above_overtemp;
    logic primary_above_full_duty;
    logic primary_above_restart;
    logic primary_below_shutdown;
  } tfpc_afe_flags_t;

endpackage

`default_nettype wire

// ---- rtl/tfpc_fan_controller.sv ----
// Operation
// (RULE1) one time base clocks the state machine and sets the modulation period
// (RULE2) in normal operation duty follows the higher of both control inputs
// (RULE3) control level from 30% to 70% of supply maps linearly to 0..100% duty
// (RULE4) primary above full duty level forces 100% duty, fault or not
// (RULE5) power-up performs a complete internal reset without external input
// (RULE6) primary below shutdown threshold shuts down at once, output and fault released
// (RULE7) primary above restart threshold resets as power-up, then startup and run
// (RULE8) every start from off forces the drive high for 64 modulation periods
// (RULE9) after the startup interval duty follows the higher control input
// (RULE10) fault output low when primary exceeds the overtemperature threshold
// (RULE11) fault releases below overtemperature threshold; modulation unaffected by fault
// (RULE12) both inputs below sleep threshold in normal operation enter sleep
// (RULE13) system grounds the sleep threshold to disable sleep
// (RULE14) sleep keeps fault inactive and drive released
// (RULE15) sleep ends only when either input rises above the wake threshold
// (RULE16) leaving sleep behaves like power-on, full startup interval included
// (RULE17) after reset the fan waits until an input is above the wake threshold
// (RULE18) at power-up drive is held low and fault inactive
// (RULE19) primary below shutdown at power-up keeps the device shut down
// (RULE20) external logic pulls primary low to request shutdown
// (RULE21) comparator results arrive as synchronised flags, duty as a digital code
// (RULE22) a triangle up/down counter against the duty code forms the modulator
// (RULE23) startup interval equals sixty-four time base periods
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module tfpc_fan_controller #(
  parameter int unsigned TIMEBASE_STEP_CYCLES = tfpc_pkg::STEP_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       sys_rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire tfpc_pkg::tfpc_afe_flags_t  afe_flags,
  input  wire logic [7:0]                 primary_control_input,
  input  wire logic [7:0]                 secondary_control_input,
  output logic                            fan_drive_out,
  output logic                            fan_drive_oe,
  input  wire logic                       overtemp_fault_n_in,
  output logic                            overtemp_fault_n_out,
  output logic                            overtemp_fault_n_oe
);
  import tfpc_pkg::*;

  localparam int unsigned SYNC_W = $bits(tfpc_afe_flags_t) + 1;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_q1;
  logic [SYNC_W-1:0] sync_q2;
  logic [SYNC_W-1:0] sync_q3;
  logic [SYNC_W-1:0] sync_val;
  tfpc_afe_flags_t   flags;
  logic              fault_pin;

  assign sync_raw = {overtemp_fault_n_in, afe_flags};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          sync_q1[gi]  <= 1'b0;
          sync_q2[gi]  <= 1'b0;
          sync_q3[gi]  <= 1'b0;
          sync_val[gi] <= 1'b0;
        end else begin
          sync_q1[gi] <= sync_raw[gi];
          sync_q2[gi] <= sync_q1[gi];
          sync_q3[gi] <= sync_q2[gi];
          // a change counts only once two stages agree
          if (sync_q2[gi] == sync_q3[gi]) begin
            sync_val[gi] <= sync_q3[gi]; // RULE21
          end
        end
      end
    end
  endgenerate

  assign flags     = tfpc_afe_flags_t'(sync_val[SYNC_W-2:0]);
  assign fault_pin = sync_val[SYNC_W-1];

  // ----------------------------------------------------------------
  // shutdown reset
  // ----------------------------------------------------------------
  // the raw pin is used on purpose: shutdown must not wait for a clock edge
  logic core_rst;

  assign core_rst = sys_rst | afe_flags.primary_below_shutdown; // RULE5 RULE6 RULE20

  // ----------------------------------------------------------------
  // registers seen by software
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic       sleep_enable;
  logic       force_full;
  logic       setup_phase;
  logic       access_wr;
  logic       addr_hit;
  logic       ctrl_wr;

  assign sleep_enable = ctrl[CTRL_SLEEP_EN_BIT];
  assign force_full   = ctrl[CTRL_FORCE_FULL_BIT];
  assign setup_phase  = psel & ~penable;
  assign addr_hit     = (paddr == CTRL_OFS) | (paddr == STATUS_OFS) |
                        (paddr == STARTUP_OFS) | (paddr == DUTY_OFS);
  assign access_wr    = psel & penable & pwrite;
  assign ctrl_wr      = access_wr & (paddr == CTRL_OFS);
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~addr_hit;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // duty mapping
  // ----------------------------------------------------------------
  logic [7:0] primary_duty;
  logic [7:0] secondary_duty;
  logic [7:0] higher_duty;
  logic [7:0] applied_duty;

  function automatic logic [7:0] level_to_duty(input logic [7:0] level);
    logic [7:0] duty;
    duty = 8'h00;
    if (level >= LEVEL_HI) begin
      duty = DUTY_SPAN;
    end else if (level > LEVEL_LO) begin
      duty = level - LEVEL_LO; // RULE3
    end
    return duty;
  endfunction

  assign primary_duty   = level_to_duty(primary_control_input);
  assign secondary_duty = level_to_duty(secondary_control_input);
  assign higher_duty    = (primary_duty > secondary_duty) ? primary_duty
                                                          : secondary_duty; // RULE2
  assign applied_duty   = (force_full | flags.primary_above_full_duty) ? DUTY_SPAN
                                                                       : higher_duty; // RULE4

  // ----------------------------------------------------------------
  // time base and triangle counter
  // ----------------------------------------------------------------
  tfpc_state_t state;
  tfpc_state_t next_state;
  logic [31:0] div_cnt;
  logic        tick;
  logic [7:0]  tri_cnt;
  logic [7:0]  next_tri_cnt;
  logic        tri_down;
  logic        next_tri_down;
  logic        tri_top;
  logic        tri_bottom;
  logic        period_end;
  logic        fan_active;

  assign tick       = (div_cnt == 32'(TIMEBASE_STEP_CYCLES - 1)); // RULE1
  assign tri_top    = (tri_cnt == DUTY_SPAN - 8'h01);
  assign tri_bottom = (tri_cnt == 8'h00);
  assign period_end = tick & tri_down & tri_bottom; // RULE22
  assign fan_active = (state == ST_STARTUP) | (state == ST_RUN);

  always_ff @(posedge clock or posedge core_rst) begin
    if (core_rst) begin
      div_cnt <= 32'h0000_0000;
    end else begin
      div_cnt <= tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;
    end
  end

  always_comb begin
    next_tri_cnt  = tri_cnt;
    next_tri_down = tri_down;
    if (!fan_active) begin
      // held at the bottom so each start begins on a period boundary
      next_tri_cnt  = 8'h00;
      next_tri_down = 1'b0;
    end else if (tick) begin
      if (!tri_down && tri_top) begin
        next_tri_down = 1'b1;
        next_tri_cnt  = tri_cnt - 8'h01;
      end else if (tri_down && tri_bottom) begin
        next_tri_down = 1'b0;
        next_tri_cnt  = tri_cnt + 8'h01;
      end else if (tri_down) begin
        next_tri_cnt = tri_cnt - 8'h01;
      end else begin
        next_tri_cnt = tri_cnt + 8'h01; // RULE22
      end
    end
  end

  always_ff @(posedge clock or posedge core_rst) begin
    if (core_rst) begin
      tri_cnt  <= 8'h00;
      tri_down <= 1'b0;
    end else begin
      tri_cnt  <= next_tri_cnt;
      tri_down <= next_tri_down;
    end
  end

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  logic [6:0] startup_cnt;
  logic [6:0] next_startup_cnt;
  logic       startup_done;
  logic       sleep_request;
  logic       wake_request;

  assign startup_done  = period_end &
                         (startup_cnt == 7'(STARTUP_PERIODS - 1)); // RULE8 RULE23
  assign sleep_request = sleep_enable & flags.primary_below_sleep &
                         flags.secondary_below_sleep; // RULE12 RULE13
  assign wake_request  = flags.primary_above_wake |
                         flags.secondary_above_wake; // RULE15

  always_comb begin
    next_state       = state;
    next_startup_cnt = startup_cnt;
    unique case (state)
      ST_HALT: begin
        // stays here while the restart comparison is low
        if (tick && flags.primary_above_restart) begin // RULE7 RULE19
          next_state = wake_request ? ST_STARTUP : ST_SLEEP; // RULE17
        end
        next_startup_cnt = 7'h00;
      end
      ST_SLEEP: begin
        if (tick && wake_request) begin
          next_state = ST_STARTUP; // RULE16
        end
        next_startup_cnt = 7'h00;
      end
      ST_STARTUP: begin
        if (startup_done) begin
          next_state = ST_RUN; // RULE9
        end else if (period_end) begin
          next_startup_cnt = startup_cnt + 7'h01;
        end
      end
      ST_RUN: begin
        if (tick && sleep_request) begin
          next_state = ST_SLEEP; // RULE12
        end
        next_startup_cnt = 7'h00;
      end
    endcase
  end

  always_ff @(posedge clock or posedge core_rst) begin
    if (core_rst) begin
      state       <= ST_HALT; // RULE6 RULE7
      startup_cnt <= 7'h00;
    end else begin
      state       <= next_state;
      startup_cnt <= next_startup_cnt;
    end
  end

  // ----------------------------------------------------------------
  // drive and fault outputs
  // ----------------------------------------------------------------
  logic drive;
  logic next_drive;
  logic fault;
  logic next_fault;

  assign next_drive = (state == ST_STARTUP) |
                      ((state == ST_RUN) & (tri_cnt < applied_duty)); // RULE8 RULE9 RULE22
  // fault looks at the comparator and the fan state, never at the drive path
  assign next_fault = fan_active & flags.primary_above_overtemp; // RULE10 RULE11 RULE14

  always_ff @(posedge clock or posedge core_rst) begin
    if (core_rst) begin
      drive <= 1'b0; // RULE18
      fault <= 1'b0;
    end else begin
      drive <= next_drive;
      fault <= next_fault;
    end
  end

  assign fan_drive_out        = drive;
  // driven low during power-up halt, released in shutdown and sleep
  assign fan_drive_oe         = ~afe_flags.primary_below_shutdown &
                                (state != ST_SLEEP); // RULE6 RULE14 RULE18
  assign overtemp_fault_n_out = 1'b0;
  assign overtemp_fault_n_oe  = fault & ~afe_flags.primary_below_shutdown; // RULE6 RULE10

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] startup_word;
  logic [31:0] duty_word;
  logic [31:0] read_word;

  assign status_word  = (32'(state) << STATUS_STATE_LSB) |
                        (32'(drive) << STATUS_DRIVE_BIT) |
                        (32'(fan_drive_oe) << STATUS_DRIVE_OE_BIT) |
                        (32'(fault) << STATUS_FAULT_BIT) |
                        (32'(fault_pin) << STATUS_FPIN_BIT) |
                        (32'(flags) << STATUS_FLAGS_LSB);
  assign startup_word = 32'(startup_cnt);
  assign duty_word    = 32'(primary_duty) |
                        (32'(secondary_duty) << DUTY_SEC_LSB) |
                        (32'(applied_duty) << DUTY_APPLIED_LSB);
  assign read_word    = (paddr == CTRL_OFS)    ? 32'(ctrl) :
                        (paddr == STATUS_OFS)  ? status_word :
                        (paddr == STARTUP_OFS) ? startup_word :
                        (paddr == DUTY_OFS)    ? duty_word : 32'h0000_0000;

  // captured in the setup cycle so the access phase shows a stable word
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : read_word;
    end
  end

endmodule

`default_nettype wire

// ---- bench/tfpc_fan_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// drive transistor base and supervisor fault line
// ----------------------------------------------------------------
module tfpc_fan_model (
  input  wire logic drive_out,
  input  wire logic drive_oe,
  input  wire logic fault_out,
  input  wire logic fault_oe,
  output logic      fan_pin,
  output logic      fault_pin
);
  // base resistor pulls a released drive low: the fan stops
  assign fan_pin   = drive_oe ? drive_out : 1'b0;
  // open-collector fault line, pull-up on the supervisor side
  assign fault_pin = fault_oe ? fault_out : 1'b1;
endmodule

`default_nettype wire

// ---- bench/tfpc_fan_controller_chk.sv ----
`timescale 1ns/100ps
`default_nettype none

module tfpc_fan_controller_chk
  import tfpc_pkg::*;
#(
  parameter int unsigned TIMEBASE_STEP_CYCLES = STEP_CYCLES
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire tfpc_pkg::tfpc_afe_flags_t  afe_flags,
  input wire logic [7:0]                 primary_control_input,
  input wire logic [7:0]                 secondary_control_input,
  input wire logic                       fan_drive_out,
  input wire logic                       fan_drive_oe,
  input wire logic                       overtemp_fault_n_in,
  input wire logic                       overtemp_fault_n_out,
  input wire logic                       overtemp_fault_n_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire acc    = psel && penable;
  wire mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS)
             || (paddr == STARTUP_OFS) || (paddr == DUTY_OFS);

  a_shutdown_release: assert property (afe_flags.primary_below_shutdown |->
    !fan_drive_oe && !overtemp_fault_n_oe) else $error("outputs held during shutdown");
  a_fault_pulls_low: assert property (overtemp_fault_n_oe |-> !overtemp_fault_n_out)
    else $error("fault pin not pulled low");
  a_fault_clears: assert property (!afe_flags.primary_above_overtemp [*8] |=>
    !overtemp_fault_n_oe) else $error("fault stays without overtemperature");
  a_fault_cause: assert property ($rose(overtemp_fault_n_oe) |->
    $past(afe_flags.primary_above_overtemp, 3)) else $error("fault without cause");
  a_full_duty_on: assert property (afe_flags.primary_above_full_duty [*8] ##0
    (fan_drive_oe && overtemp_fault_n_oe) |-> fan_drive_out) else $error("not full duty");
  a_reset_quiet: assert property ($fell(sys_rst) |->
    !fan_drive_out && !overtemp_fault_n_oe) else $error("outputs active after reset");
  a_apb_ready: assert property (acc |-> pready) else $error("no ready in access");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");

  cover property ($rose(overtemp_fault_n_oe));
  cover property (acc && pslverr);
  cover property ($fell(fan_drive_out) && fan_drive_oe);
endmodule

bind tfpc_fan_controller tfpc_fan_controller_chk #(
  .TIMEBASE_STEP_CYCLES(TIMEBASE_STEP_CYCLES)
) u_chk (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .afe_flags(afe_flags), .primary_control_input(primary_control_input),
  .secondary_control_input(secondary_control_input), .fan_drive_out(fan_drive_out),
  .fan_drive_oe(fan_drive_oe), .overtemp_fault_n_in(overtemp_fault_n_in),
  .overtemp_fault_n_out(overtemp_fault_n_out), .overtemp_fault_n_oe(overtemp_fault_n_oe)
);

`default_nettype wire

// ---- bench/test_thermal_fan_pwm_controller.sv ----
`timescale 1ns/100ps
`default_nettype none

module test_thermal_fan_pwm_controller;
  import tfpc_pkg::*;
  localparam int STEP = 2;
  localparam int PER  = TRI_STEPS * STEP;
  logic            clock, sys_rst, psel, penable, pwrite, pready, pslverr, err, mon;
  logic            drv, drv_oe, f_out, f_oe, fan_pin, fault_pin;
  logic [7:0]      paddr, pri, sec;
  logic [31:0]     pwdata, prdata, rd;
  tfpc_afe_flags_t flags;
  int              n_mismatch, cmp_count, h, su_low;
  time             t0;
  int              tp [4] = '{8'h80, 8'h5A, 8'h4C, 8'hB3};
  int              ts [4] = '{8'h64, 8'h96, 8'h4C, 8'h00};
  int              td [4] = '{52, 74, 0, 103};

  tfpc_fan_controller #(.TIMEBASE_STEP_CYCLES(STEP)) dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .afe_flags(flags), .primary_control_input(pri), .secondary_control_input(sec),
    .fan_drive_out(drv), .fan_drive_oe(drv_oe), .overtemp_fault_n_in(fault_pin),
    .overtemp_fault_n_out(f_out), .overtemp_fault_n_oe(f_oe));
  tfpc_fan_model fan (.drive_out(drv), .drive_oe(drv_oe), .fault_out(f_out),
    .fault_oe(f_oe), .fan_pin(fan_pin), .fault_pin(fault_pin));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no limit of its own: a missing ready is left to the watchdog
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // polling is bounded; a miss shows up in the caller's compare
  task automatic wait_state(input logic [1:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0);
      n++;
    end while (rd[1:0] !== s && n < 10000);
  endtask

  task automatic hi_count;
    h = 0;
    repeat (PER) begin
      @(negedge clock);
      h += int'(fan_pin === 1'b1);
    end
    // back on a rising edge, where the caller drives stimulus
    @(posedge clock);
  endtask

  function automatic logic near(input int v, input int e, input int tol);
    return (v >= e - tol) && (v <= e + tol);
  endfunction

  always @(posedge clock) if (mon && fan_pin !== 1'b1) su_low++;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_mismatch++;
    finish_test;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; pri = 8'h80; sec = 8'h64; mon = 1'b0; su_low = 0;
    n_mismatch = 0; cmp_count = 0;
    flags = '0;
    flags.primary_below_shutdown = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clock);
    chk("drive_oe", drv_oe, 1'b0);
    chk("fault_pin", fault_pin, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("state", rd[1:0], ST_HALT);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl_rst", rd, 32'(CTRL_RST));
    apb(1'b1, CTRL_OFS, 32'hFFFF_FFFE);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", rd, 32'h2);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status_ro", rd[1:0], ST_HALT);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h1);
    // shutdown released but no input above wake: fan must stay off
    flags.primary_below_shutdown <= 1'b0;
    flags.primary_above_restart <= 1'b1;
    wait_state(ST_SLEEP);
    chk("wait_sleep", rd[1:0], ST_SLEEP);
    chk("sleep_oe", drv_oe, 1'b0);
    flags.primary_above_wake <= 1'b1;
    wait_state(ST_STARTUP);
    t0 = $time;
    mon <= 1'b1;
    wait_state(ST_RUN);
    mon <= 1'b0;
    chk("startup_len", near(int'(($time - t0) / 10), 64 * PER, 8), 1'b1);
    chk("startup_low", su_low, 0);
    apb(1'b0, DUTY_OFS, 32'h0);
    chk("duty_map", rd, 32'h0034_1834);
    for (int i = 0; i < 4; i++) begin
      pri <= 8'(tp[i]);
      sec <= 8'(ts[i]);
      repeat (PER) @(posedge clock);
      hi_count;
      chk("duty", near(h, (td[i] == 0) ? 0 : STEP * (2 * td[i] - 1), 2 * STEP), 1'b1);
    end
    pri <= 8'h80;
    sec <= 8'h64;
    flags.primary_above_full_duty <= 1'b1;
    flags.primary_above_overtemp <= 1'b1;
    repeat (PER) @(posedge clock);
    chk("fault_on", fault_pin, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("fault_stat", rd[5:4], 2'b01);
    hi_count;
    chk("full_duty", h, PER);
    flags.primary_above_overtemp <= 1'b0;
    repeat (10) @(posedge clock);
    chk("fault_off", fault_pin, 1'b1);
    flags.primary_above_full_duty <= 1'b0;
    // software override of the duty, control level back at mid range
    apb(1'b1, CTRL_OFS, 32'h3);
    repeat (PER) @(posedge clock);
    hi_count;
    chk("force_full", h, PER);
    // sleep disabled: both inputs low must not stop the fan
    apb(1'b1, CTRL_OFS, 32'h0);
    flags <= 8'h32;
    repeat (50) @(posedge clock);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("no_sleep", rd[1:0], ST_RUN);
    apb(1'b1, CTRL_OFS, 32'h1);
    wait_state(ST_SLEEP);
    chk("sleep", rd[1:0], ST_SLEEP);
    flags.primary_above_overtemp <= 1'b1;
    repeat (10) @(posedge clock);
    chk("sleep_oe", drv_oe, 1'b0);
    chk("sleep_fault", fault_pin, 1'b1);
    flags.primary_above_overtemp <= 1'b0;
    flags.primary_below_sleep <= 1'b0;
    repeat (50) @(posedge clock);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("hysteresis", rd[1:0], ST_SLEEP);
    flags.secondary_above_wake <= 1'b1;
    wait_state(ST_STARTUP);
    chk("wake", rd[1:0], ST_STARTUP);
    @(negedge clock);
    chk("wake_drive", fan_pin, 1'b1);
    @(posedge clock);
    flags.primary_below_shutdown <= 1'b1;
    @(negedge clock);
    chk("shut_oe", drv_oe, 1'b0);
    chk("shut_fault", fault_pin, 1'b1);
    @(posedge clock);
    flags.primary_below_shutdown <= 1'b0;
    wait_state(ST_STARTUP);
    chk("restart", rd[1:0], ST_STARTUP);
    finish_test;
  end
endmodule

`default_nettype wire
